/* core/ldh_host_port.sv */
// module: parallel and serial host port of the bitmap display driver
// How it works
// - interface select high picks parallel port, low picks serial port
// - bus style high gives enable plus read/write; low gives read/write strobes
// - data/command high reads display data; low reads status byte
// - write with data/command low loads the instruction register
// - serial receiver is an 8-bit shift register and 3-bit counter
// - serial inputs accepted only while selected and serial mode chosen
// - deselect clears shift register and bit counter
// - each serial clock rise shifts one bit, most significant first
// - eighth serial clock rise transfers the byte
// - data/command sampled at eighth rise marks data or instruction
// - partial serial byte at deselect or reset becomes an instruction
// - serial mode has no read path
// - ram read goes to the holder; host gets it next read
// - ram write is held and committed on the next data write; a data read before that replaces it uncommitted
// - host accesses answered only while chip select low
// - deselected: data bus floats, control and serial inputs ignored
// - reset acts regardless of chip select
module ldh_host_port (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic parallel_select,
   input wire logic bus_style_select,
   input wire logic data_command_select,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic ser_data,
   input wire logic ser_clk,
   input wire logic [7:0] parallel_data_bus_in,
   output logic [7:0] parallel_data_bus_out,
   output logic parallel_data_bus_oe_n,
   input wire logic [7:0] status_byte,
   input wire logic [7:0] ram_rdata,
   output ldh_pkg::ldh_ram_req_t ram_req,
   output ldh_pkg::ldh_xfer_t instr_out
);
   ////////////////////////////////////////////////////////////////////
   // three-stage input synchronisers, change taken when stages 2 and 3 agree
   localparam int NS = 14;
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
   logic [NS-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;
   assign raw = {parallel_data_bus_in, reset_n, cs_n, data_command_select,
                 rd_strobe, wr_strobe, ser_clk};
   // cs_n and strobes idle high, reset_n idle high
   localparam logic [NS-1:0] SYNC_RST = 14'h0036;

   always_comb begin
      nxt_s1 = raw;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      nxt_flt = flt_ff;
      for (int i = 0; i < NS; i++) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_flt[i] = s3_ff[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_ff <= SYNC_RST;
         s2_ff <= SYNC_RST;
         s3_ff <= SYNC_RST;
         flt_ff <= SYNC_RST;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
         flt_ff <= nxt_flt;
      end
   end

   // serial data sampled separately (3 stages, agreement filter)
   logic sd1_ff, sd2_ff, sd3_ff, sd_ff;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sd1_ff <= 1'b0;
         sd2_ff <= 1'b0;
         sd3_ff <= 1'b0;
         sd_ff <= 1'b0;
      end else begin
         sd1_ff <= ser_data;
         sd2_ff <= sd1_ff;
         sd3_ff <= sd2_ff;
         sd_ff <= (sd2_ff == sd3_ff) ? sd3_ff : sd_ff;
      end
   end

   logic [7:0] pd;
   logic rstn_s, csn_s, dc_s, rd_s, wr_s, sclk_s;
   assign {pd, rstn_s, csn_s, dc_s, rd_s, wr_s, sclk_s} = flt_ff;

   ////////////////////////////////////////////////////////////////////
   // previous levels for edge detection
   logic sclk_d_ff, csn_d_ff, rstn_d_ff, act_d_ff;
   logic par_act;
   logic par_rd;
   // bus style decode
   // 68 style: rd pin is enable (high active), wr pin is read/not-write
   assign par_act = bus_style_select ? rd_s : (!rd_s || !wr_s);
   assign par_rd = bus_style_select ? wr_s : !rd_s;

   // parallel cycle only when selected, pin reset high
   logic par_sel;
   assign par_sel = parallel_select && !csn_s && rstn_s;
   logic cyc_start, cyc_end;
   assign cyc_start = par_sel && par_act && !act_d_ff;
   assign cyc_end = act_d_ff && !(par_sel && par_act);

   // serial inputs live only when selected and serial mode
   logic ser_en;
   assign ser_en = !parallel_select && !csn_s && rstn_s;
   logic sclk_rise;
   assign sclk_rise = ser_en && sclk_s && !sclk_d_ff;

   ////////////////////////////////////////////////////////////////////
   // serial shifter, holder and parallel bus state
   logic [7:0] sh_ff, nxt_sh;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [7:0] hold_ff, nxt_hold;
   logic hold_dirty_ff, nxt_hold_dirty;
   logic [7:0] dout_ff, nxt_dout;
   logic oe_n_ff, nxt_oe_n;
   logic rd_cyc_ff, nxt_rd_cyc;
   ldh_pkg::ldh_ram_req_t ram_ff, nxt_ram;
   ldh_pkg::ldh_xfer_t xfer_ff, nxt_xfer;
   logic abort;
   // deselect or pin reset edge while serial bits pending
   assign abort = !parallel_select && (cnt_ff != ldh_pkg::CNT_RST)
                  && ((csn_s && !csn_d_ff) || (!rstn_s && rstn_d_ff));

   always_comb begin
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      nxt_hold = hold_ff;
      nxt_hold_dirty = hold_dirty_ff;
      nxt_dout = dout_ff;
      nxt_oe_n = oe_n_ff;
      nxt_rd_cyc = rd_cyc_ff;
      nxt_ram = '0;
      nxt_xfer = '0;
      if (sclk_rise) begin
         nxt_sh = {sh_ff[6:0], sd_ff};
         nxt_cnt = cnt_ff + 3'h1;
         // eighth edge delivers the byte, data/command sampled
         if (cnt_ff == ldh_pkg::CNT_LAST) begin
            nxt_xfer.valid = 1'b1;
            nxt_xfer.is_data = dc_s;
            nxt_xfer.byte_val = {sh_ff[6:0], sd_ff};
            nxt_cnt = ldh_pkg::CNT_RST;
            // serial data goes through the holder as well
            if (dc_s) begin
               nxt_ram.wr = hold_dirty_ff;
               nxt_ram.wdata = hold_ff;
               nxt_hold = {sh_ff[6:0], sd_ff};
               nxt_hold_dirty = 1'b1;
            end
         end
      end
      // partial byte taken as an instruction
      if (abort) begin
         nxt_xfer.valid = 1'b1;
         nxt_xfer.is_data = 1'b0;
         nxt_xfer.byte_val = sh_ff;
      end
      if (csn_s || !rstn_s || parallel_select) begin
         nxt_sh = ldh_pkg::SHIFT_RST;
         nxt_cnt = ldh_pkg::CNT_RST;
      end
      if (cyc_start) begin
         nxt_rd_cyc = par_rd;
         if (par_rd) begin
            nxt_oe_n = 1'b0;
            // status or held display data onto the bus
            if (dc_s) begin
               // host gets last held word, holder refetches
               nxt_dout = hold_ff;
               nxt_ram.rd = 1'b1;
            end else begin
               nxt_dout = status_byte;
            end
         end
      end
      // fetched word lands in holder one cycle after the read request
      if (ram_ff.rd) begin
         nxt_hold = ram_rdata;
         nxt_hold_dirty = 1'b0;
      end
      if (cyc_end) begin
         nxt_oe_n = 1'b1;
         if (!rd_cyc_ff) begin
            if (dc_s) begin
               // commit previous held byte, hold the new one
               nxt_ram.wr = hold_dirty_ff;
               nxt_ram.wdata = hold_ff;
               nxt_hold = pd;
               nxt_hold_dirty = 1'b1;
            end else begin
               nxt_xfer.valid = 1'b1;
               nxt_xfer.is_data = 1'b0;
               nxt_xfer.byte_val = pd;
            end
         end
      end
      // no drive when deselected or in serial mode
      if (csn_s || !parallel_select || !rstn_s) begin
         nxt_oe_n = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sh_ff <= ldh_pkg::SHIFT_RST;
         cnt_ff <= ldh_pkg::CNT_RST;
         hold_ff <= ldh_pkg::HOLD_RST;
         hold_dirty_ff <= 1'b0;
         dout_ff <= 8'h00;
         oe_n_ff <= 1'b1;
         rd_cyc_ff <= 1'b0;
         ram_ff <= '0;
         xfer_ff <= '0;
         sclk_d_ff <= 1'b0;
         csn_d_ff <= 1'b1;
         rstn_d_ff <= 1'b1;
         act_d_ff <= 1'b0;
      end else begin
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         hold_ff <= nxt_hold;
         hold_dirty_ff <= nxt_hold_dirty;
         dout_ff <= nxt_dout;
         oe_n_ff <= nxt_oe_n;
         rd_cyc_ff <= nxt_rd_cyc;
         ram_ff <= nxt_ram;
         xfer_ff <= nxt_xfer;
         sclk_d_ff <= sclk_s;
         csn_d_ff <= csn_s;
         rstn_d_ff <= rstn_s;
         act_d_ff <= par_sel && par_act;
      end
   end

   assign parallel_data_bus_out = dout_ff;
   assign parallel_data_bus_oe_n = oe_n_ff;
   assign ram_req = ram_ff;
   assign instr_out = xfer_ff;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_bus_float_desel: assert property (@(posedge sys_clk) disable iff (!nrst)
      csn_s |=> parallel_data_bus_oe_n)
      else $error("data bus driven while deselected");
   a_serial_no_read: assert property (@(posedge sys_clk) disable iff (!nrst)
      !parallel_select |=> parallel_data_bus_oe_n)
      else $error("data bus driven in serial mode");
   a_desel_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      csn_s |=> (cnt_ff == 3'h0) && (sh_ff == 8'h00))
      else $error("shifter not cleared on deselect");
   a_eighth_byte: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sclk_rise && cnt_ff == 3'h7) |=> instr_out.valid && instr_out.is_data == $past(dc_s))
      else $error("eighth edge gave no byte");
   a_serial_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      (parallel_select || csn_s) |=> $stable(cnt_ff) || cnt_ff == 3'h0)
      else $error("serial counter moved while gated");
   a_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sclk_rise && cnt_ff != 3'h7 && !csn_s) |=> cnt_ff == $past(cnt_ff) + 3'h1)
      else $error("bit counter did not step");
   a_instr_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cyc_end && !rd_cyc_ff && !dc_s) |=> instr_out.valid && !instr_out.is_data)
      else $error("instruction write lost");
   a_status_read: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cyc_start && par_rd && !dc_s) |=> !parallel_data_bus_oe_n
         && parallel_data_bus_out == $past(status_byte))
      else $error("status read wrong");
   a_partial_instr: assert property (@(posedge sys_clk) disable iff (!nrst)
      abort |=> instr_out.valid && !instr_out.is_data)
      else $error("partial byte not taken as instruction");
endmodule : ldh_host_port

/* common/ldh_pkg.sv */
// package: shared constants and carriers for the display host port
package ldh_pkg;
   localparam int DATA_W = 8;
   localparam int CNT_W = 3;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [2:0] CNT_RST = 3'h0;
   localparam logic [2:0] CNT_LAST = 3'h7;
   localparam logic [7:0] HOLD_RST = 8'h00;

   // one decoded transfer toward the core
   typedef struct packed {
      logic valid;
      logic is_data;
      logic [7:0] byte_val;
   } ldh_xfer_t;

   // core side of the display memory
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ldh_ram_req_t;
endpackage : ldh_pkg

/* dv/ldh_mpu_model.sv */
// host processor model driving the display port pins
module ldh_mpu_model (
   input wire logic sys_clk,
   input wire logic [7:0] parallel_data_bus_out,
   output logic reset_n,
   output logic cs_n,
   output logic bus_style_select,
   output logic data_command_select,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic ser_data,
   output logic ser_clk,
   output logic [7:0] parallel_data_bus_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {reset_n, cs_n, bus_style_select, rd_strobe, wr_strobe} = 5'h1f;
      {data_command_select, ser_data, ser_clk} = 3'h0;
      parallel_data_bus_in = 8'h00;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask : step
   task automatic access(input logic sty, input logic dc, input logic wr, input logic sel,
                         input logic [7:0] wd, output logic [7:0] rd);
      bus_style_select = sty;
      rd_strobe = !sty;
      wr_strobe = 1'b1;
      data_command_select = dc;
      parallel_data_bus_in = wd;
      cs_n = !sel;
      step(4);
      if (sty) begin
         wr_strobe = !wr;
         step(4);
         rd_strobe = 1'b1;
      end else if (wr) begin
         wr_strobe = 1'b0;
      end else begin
         rd_strobe = 1'b0;
      end
      step(8);
      rd = parallel_data_bus_out;
      rd_strobe = !sty;
      // write strobe ends while data still stands
      if (!sty) begin
         wr_strobe = 1'b1;
      end
      step(8);
      wr_strobe = 1'b1;
      parallel_data_bus_in = ~wd;
      cs_n = 1'b1;
      step(4);
   endtask : access
   task automatic ser_send(input logic dc, input logic [7:0] b, input int nbits,
                           input logic by_rst);
      data_command_select = dc;
      cs_n = 1'b0;
      step(4);
      for (int i = 7; i > 7 - nbits; i--) begin
         ser_data = b[i];
         step(4);
         ser_clk = 1'b1;
         step(4);
         ser_clk = 1'b0;
      end
      step(8);
      reset_n = !by_rst;
      step(8);
      cs_n = 1'b1;
      ser_data = !ser_data;
      step(8);
      reset_n = 1'b1;
      step(12);
   endtask : ser_send
endmodule : ldh_mpu_model

/* dv/lcd_driver_host_interface_tb.sv */
// self-checking bench for the display host port
module lcd_driver_host_interface_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic sty;
      logic dc;
      logic wr;
      logic [7:0] val;
      logic [7:0] exp;
   } ldh_row_t;
   logic sys_clk, nrst, parallel_select, reset_n, cs_n, bus_style_select, data_command_select;
   logic rd_strobe, wr_strobe, ser_data, ser_clk, oe_n;
   logic [7:0] din, dout, status_byte, ram_rdata, rd, got, cap_wdata, n_instr, n_oe, n0, m0;
   ldh_pkg::ldh_ram_req_t ram_req;
   ldh_pkg::ldh_xfer_t instr_out, cap_instr;
   int miscompares = 0;
   int check_count = 0;
   // reads, status, instructions and data writes under both bus styles
   // first data read is the dummy read
   ldh_row_t rows [9] = '{
      '{1'b1, 1'b1, 1'b0, 8'h3c, ldh_pkg::HOLD_RST}, '{1'b0, 1'b1, 1'b0, 8'hc3, 8'h3c},
      '{1'b1, 1'b0, 1'b1, 8'ha5, 8'ha5}, '{1'b1, 1'b0, 1'b0, 8'h81, 8'h81},
      '{1'b0, 1'b0, 1'b1, 8'h5a, 8'h5a}, '{1'b0, 1'b0, 1'b0, 8'h7e, 8'h7e},
      '{1'b1, 1'b1, 1'b1, 8'h11, 8'hee}, '{1'b0, 1'b1, 1'b1, 8'h22, 8'h11},
      '{1'b1, 1'b1, 1'b1, 8'h33, 8'h22}};
   ldh_host_port DUT (.sys_clk(sys_clk), .nrst(nrst), .reset_n(reset_n), .cs_n(cs_n),
      .parallel_select(parallel_select), .bus_style_select(bus_style_select),
      .data_command_select(data_command_select), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
      .ser_data(ser_data), .ser_clk(ser_clk), .parallel_data_bus_in(din),
      .parallel_data_bus_out(dout), .parallel_data_bus_oe_n(oe_n), .status_byte(status_byte),
      .ram_rdata(ram_rdata), .ram_req(ram_req), .instr_out(instr_out));
   ldh_mpu_model mpu (.sys_clk(sys_clk), .parallel_data_bus_out(dout), .reset_n(reset_n),
      .cs_n(cs_n), .bus_style_select(bus_style_select), .data_command_select(data_command_select),
      .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .ser_data(ser_data), .ser_clk(ser_clk),
      .parallel_data_bus_in(din));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // capture one-cycle pulses and count cycles with the bus driven
   always @(posedge sys_clk) begin
      if (instr_out.valid === 1'b1) begin
         cap_instr <= instr_out;
         n_instr <= n_instr + 8'h01;
      end
      if (ram_req.wr === 1'b1) cap_wdata <= ram_req.wdata;
      if (oe_n === 1'b0) n_oe <= n_oe + 8'h01;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, parallel_select, status_byte, ram_rdata} = {2'h1, 16'h0000};
      {cap_wdata, n_instr, n_oe, cap_instr} = {8'hee, 16'h0000, 10'h000};
      repeat (5) @(posedge sys_clk);
      #5 nrst = 1'b1;
      mpu.step(8);
      foreach (rows[i]) begin
         status_byte = rows[i].val;
         ram_rdata = rows[i].val;
         mpu.access(rows[i].sty, rows[i].dc, rows[i].wr, 1'b1, rows[i].val, rd);
         got = !rows[i].wr ? rd : rows[i].dc ? cap_wdata : cap_instr.byte_val;
         chk("row", got, rows[i].exp);
         $display("row %0d done", i);
      end
      parallel_select = 1'b0;
      for (int d = 0; d < 2; d++) begin
         n0 = n_instr;
         mpu.ser_send(d[0], d[0] ? 8'h4b : 8'hb4, 8, 1'b0);
         chk("ser count", n_instr - n0, 8'h01);
         chk("ser byte", cap_instr.byte_val, d[0] ? 8'h4b : 8'hb4);
         chk("ser kind", {7'h00, cap_instr.is_data}, {7'h00, d[0]});
      end
      $display("serial bytes done");
      mpu.ser_send(1'b1, 8'ha0, 3, 1'b0);
      chk("part desel", cap_instr.byte_val, 8'h05);
      chk("part desel kind", {7'h00, cap_instr.is_data}, 8'h00);
      mpu.ser_send(1'b1, 8'h80, 2, 1'b1);
      chk("part reset", cap_instr.byte_val, 8'h02);
      chk("part reset kind", {7'h00, cap_instr.is_data}, 8'h00);
      $display("partial bytes done");
      m0 = n_oe;
      mpu.access(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, rd);
      chk("ser read", n_oe, m0);
      $display("serial read done");
      parallel_select = 1'b1;
      n0 = n_instr;
      mpu.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h99, rd);
      mpu.access(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, rd);
      chk("desel write", n_instr, n0);
      chk("desel read", n_oe, m0);
      $display("deselect done");
      nrst = 1'b0;
      mpu.step(2);
      nrst = 1'b1;
      mpu.step(8);
      mpu.access(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, rd);
      chk("rst hold", rd, ldh_pkg::HOLD_RST);
      $display("reset done");
      close_out();
   end
endmodule : lcd_driver_host_interface_tb
